// ==== icw_pkg.sv ====
// Package for the identify capability word generator.
// Assumes a single 100 MHz clock domain and 16-bit identify words.
package icw_pkg;
  localparam int WORD_W = 16;
  localparam int WORD_ADDR_W = 8;
  localparam logic [7:0] WORD_MAJOR = 8'h50;
  localparam logic [7:0] WORD_MINOR = 8'h51;
  localparam logic [7:0] WORD_SUP82 = 8'h52;
  localparam logic [7:0] WORD_SUP83 = 8'h53;
  localparam logic [7:0] WORD_EN85 = 8'h55;
  localparam logic [7:0] WORD_EN86 = 8'h56;
  localparam logic [7:0] WORD_UDMA = 8'h58;
  localparam logic [7:0] WORD_VALID53 = 8'h35;
  localparam logic [15:0] VER_NONE0 = 16'h0000;
  localparam logic [15:0] VER_NONE1 = 16'hFFFF;
  localparam logic [15:0] MAJOR_MASK = 16'h003C;
  localparam logic [15:0] SUP82_MASK = 16'h77EF;
  localparam logic [15:0] SUP83_MASK = 16'h017F;
  localparam logic [15:0] SUP83_FIXED = 16'h4000;
  localparam int SETMAX_BIT = 8;
  localparam int UDMA_MODES = 5;
  localparam int UDMA_SEL_LSB = 8;
  localparam int UDMA_MODE4_SEL = 12;
  localparam int VALID53_UDMA_BIT = 2;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  typedef enum logic [0:0] {
    ICW_IDLE = 1'b0,
    ICW_SHOW = 1'b1
  } icw_state_e;
endpackage

// ==== icw_word_rom.sv ====
// Small word store holding the assembled identify words.
// Assumes single clock, registered read data.
`timescale 1ns/1ps
module icw_word_rom #(
  parameter int DEPTH = 7
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [2:0] rd_sel,
  input wire logic [16*DEPTH-1:0] words,
  output logic [15:0] rd_data
);
  import icw_pkg::*;
  logic [15:0] mem [DEPTH];
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_w
      assign mem[g] = words[16*g +: 16];
    end
  endgenerate
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= RESET_WORD;
    end else if (int'(rd_sel) < DEPTH) begin
      rd_data <= mem[rd_sel];
    end else begin
      rd_data <= RESET_WORD;
    end
  end
endmodule

// ==== icw_capability_words.sv ====
// Generates identify words 80 to 83, 85, 86 and 88 plus word 53 bit 2.
// Assumes configuration inputs are synchronous; host reads by word number.
`timescale 1ns/1ps
// Functional notes
// [R1] Major word zero or ones means unreported.
// [R2] Minor word carries revision code.
// [R3] Major bits 5..2 claim revisions; others zero.
// [R4] Word 82 bit 4 always zero.
// [R5] Word 82 support flags set individually.
// [R6] Word 83 bit15 zero, bit14 one.
// [R7] Word 83 support flags set individually.
// [R8] Word 85 shows enabled word 82 features.
// [R9] Word 86 set-max flag needs password.
// [R10] Bit 12 set when mode 4 selected.
// [R11] Ultra DMA support reported cumulatively.
// [R12] Word 53 bit 2 marks valid DMA word.
// [R13] One selected mode, and it is supported.
module icw_capability_words (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic report_version,
  input wire logic [3:0] major_support,
  input wire logic [15:0] minor_code,
  input wire logic [15:0] sup82_flags,
  input wire logic [15:0] sup83_flags,
  input wire logic [15:0] en82_flags,
  input wire logic [15:0] en83_flags,
  input wire logic setmax_pw_set,
  input wire logic [2:0] udma_max_mode,
  input wire logic udma_supported,
  input wire logic udma_sel_req,
  input wire logic [2:0] udma_sel_mode,
  input wire logic udma_sel_clear,
  input wire logic rd_req,
  input wire logic [icw_pkg::WORD_ADDR_W-1:0] rd_word,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic word53_udma_valid
);
  import icw_pkg::*;

  function automatic logic [4:0] mode_onehot(input logic [2:0] m);
    mode_onehot = (m < 3'h5) ? 5'(5'h01 << m) : 5'h00;
  endfunction

  function automatic logic [2:0] word_slot(input logic [WORD_ADDR_W-1:0] w);
    case (w)
      WORD_MAJOR: word_slot = 3'h0;
      WORD_MINOR: word_slot = 3'h1;
      WORD_SUP82: word_slot = 3'h2;
      WORD_SUP83: word_slot = 3'h3;
      WORD_EN85: word_slot = 3'h4;
      WORD_EN86: word_slot = 3'h5;
      WORD_UDMA: word_slot = 3'h6;
      default: word_slot = 3'h7;
    endcase
  endfunction

  logic [4:0] udma_sel_ff;
  logic [4:0] nxt_udma_sel;
  logic [4:0] udma_sup;
  logic [4:0] req_onehot;
  logic [4:0] udma_sel_shown;
  logic sel_hit;
  logic rd_valid_ff;
  logic [2:0] rd_sel_ff;
  logic [2:0] nxt_rd_sel;
  icw_state_e state_ff;
  icw_state_e nxt_state;
  logic [15:0] w80, w81, w82, w83, w85, w86, w88;
  logic [15:0] major_raw;
  logic [15:0] minor_raw;

  // Cumulative support: mode n supported implies all lower modes.
  assign udma_sup = udma_supported ? 5'((6'h02 << udma_max_mode) - 6'h01) : 5'h00; // see [R11]
  assign req_onehot = mode_onehot(udma_sel_mode);
  // A selection is accepted only for a supported mode, replacing any other.
  assign sel_hit = udma_sel_req && ((req_onehot & udma_sup) != 5'h00);
  assign nxt_udma_sel = udma_sel_clear ? 5'h00 :
    sel_hit ? req_onehot : (udma_sel_ff & udma_sup); // see [R13]

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      udma_sel_ff <= 5'h00;
    end else begin
      udma_sel_ff <= nxt_udma_sel;
    end
  end

  assign major_raw = {10'h000, major_support, 2'b00} & MAJOR_MASK; // see [R3]
  assign w80 = (report_version && major_raw != VER_NONE0) ? major_raw : VER_NONE0; // see [R1]
  assign minor_raw = report_version ? minor_code : VER_NONE0;
  assign w81 = minor_raw; // see [R2]
  assign w82 = sup82_flags & SUP82_MASK; // see [R4] see [R5]
  assign w83 = (sup83_flags & SUP83_MASK) | SUP83_FIXED; // see [R6] see [R7]
  assign w85 = en82_flags & sup82_flags & SUP82_MASK; // see [R8]
  assign w86 = (en83_flags & sup83_flags & SUP83_MASK & ~(16'h0001 << SETMAX_BIT))
    | ({15'h0000, setmax_pw_set & sup83_flags[SETMAX_BIT]} << SETMAX_BIT); // see [R9]
  // A selection whose mode is no longer supported is hidden at once.
  assign udma_sel_shown = udma_sel_ff & udma_sup; // see [R13]
  // Mode 4 selected flag lands on bit 12, lower modes below it.
  assign w88 = {3'h0, udma_sel_shown, 3'h0, udma_sup}; // see [R10]
  assign word53_udma_valid = udma_supported; // see [R12]

  assign nxt_rd_sel = word_slot(rd_word);

  always_comb begin
    case (state_ff)
      ICW_IDLE: nxt_state = rd_req ? ICW_SHOW : ICW_IDLE;
      ICW_SHOW: nxt_state = rd_req ? ICW_SHOW : ICW_IDLE;
      default: nxt_state = ICW_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ICW_IDLE;
      rd_sel_ff <= 3'h7;
      rd_valid_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      rd_sel_ff <= nxt_rd_sel;
      rd_valid_ff <= rd_req;
    end
  end

  icw_word_rom #(.DEPTH(7)) u_rom (
    .clock(clock),
    .arst_n(arst_n),
    .rd_sel(rd_sel_ff),
    .words({w88, w86, w85, w83, w82, w81, w80}),
    .rd_data(rd_data)
  );

  // Data appears two edges after the request; valid follows with it.
  logic rd_valid_d_ff;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_valid_d_ff <= 1'b0;
    end else begin
      rd_valid_d_ff <= rd_valid_ff;
    end
  end
  assign rd_valid = rd_valid_d_ff;

  // Selection and support checks.
  a_udma_onehot: assert property (@(posedge clock) disable iff (!arst_n) // see [R13]
    $onehot0(w88[12:8]) && ((w88[12:8] & ~w88[4:0]) == 5'h00))
    else $error("Ultra DMA selection not one supported mode");
  a_mode4_bit: assert property (@(posedge clock) disable iff (!arst_n) // see [R10]
    udma_sel_req && !udma_sel_clear && udma_sel_mode == 3'h4 && udma_sup[4]
    |=> w88[UDMA_MODE4_SEL] || !udma_sup[4])
    else $error("Mode 4 selected flag not set");
  a_mode4_clear: assert property (@(posedge clock) disable iff (!arst_n) // see [R10]
    w88[UDMA_MODE4_SEL] |-> udma_sel_ff[4] && udma_sup[4])
    else $error("Mode 4 selected flag set without selection");
  a_sel_clear: assert property (@(posedge clock) disable iff (!arst_n) // see [R13]
    udma_sel_clear |=> w88[12:8] == 5'h00)
    else $error("Ultra DMA selection not cleared");
  a_sel_reject: assert property (@(posedge clock) disable iff (!arst_n) // see [R13]
    udma_sel_req && !udma_sel_clear && !sel_hit |=> (udma_sel_ff & ~$past(udma_sel_ff)) == 5'h00)
    else $error("Unsupported Ultra DMA mode selected");
  a_sup_cumul: assert property (@(posedge clock) disable iff (!arst_n) // see [R11]
    udma_sup[4:1] == (udma_sup[4:1] & udma_sup[3:0]))
    else $error("Ultra DMA support not cumulative");
  a_sup_top: assert property (@(posedge clock) disable iff (!arst_n) // see [R11]
    udma_supported && udma_max_mode <= 3'h4 |-> 5'(udma_sup >> udma_max_mode) == 5'h01)
    else $error("Ultra DMA highest mode flag wrong");
  a_sup_none: assert property (@(posedge clock) disable iff (!arst_n) // see [R11]
    !udma_supported |-> w88[4:0] == 5'h00)
    else $error("Ultra DMA support shown while absent");
  a_w53_valid: assert property (@(posedge clock) disable iff (!arst_n) // see [R12]
    word53_udma_valid == (udma_sup != 5'h00))
    else $error("Word 53 validity wrong");

  // Fixed bit, reserved bit and flag value checks.
  a_w83_fixed: assert property (@(posedge clock) disable iff (!arst_n) // see [R6]
    w83[15:14] == 2'b01 && w83[13:9] == 5'h00 && !w83[7])
    else $error("Word 83 signature bits wrong");
  a_w82_bit4: assert property (@(posedge clock) disable iff (!arst_n) // see [R4]
    !w82[4] && !w82[15] && !w82[11])
    else $error("Word 82 fixed bits not zero");
  a_major_bits: assert property (@(posedge clock) disable iff (!arst_n) // see [R3]
    (w80 & ~MAJOR_MASK) == 16'h0000)
    else $error("Major word reserved bits set");
  a_major_none: assert property (@(posedge clock) disable iff (!arst_n) // see [R1]
    !report_version |-> w80 == VER_NONE0 && w81 == VER_NONE0)
    else $error("Version reported while disabled");
  a_minor_pass: assert property (@(posedge clock) disable iff (!arst_n) // see [R2]
    report_version |-> w81 == minor_code)
    else $error("Minor code not reported");
  a_en82_mirror: assert property (@(posedge clock) disable iff (!arst_n) // see [R8]
    (w85 & ~w82) == 16'h0000)
    else $error("Enabled flag without support");
  a_w85_fixed: assert property (@(posedge clock) disable iff (!arst_n) // see [R8]
    !w85[15] && !w85[11] && !w85[4])
    else $error("Word 85 fixed bits not zero");
  a_setmax_pw: assert property (@(posedge clock) disable iff (!arst_n) // see [R9]
    !setmax_pw_set |-> !w86[SETMAX_BIT])
    else $error("Set-max flag without password");
  a_w86_reserved: assert property (@(posedge clock) disable iff (!arst_n) // see [R9]
    w86[15:9] == 7'h00 && !w86[7])
    else $error("Word 86 reserved bits set");
  a_w83_flags: assert property (@(posedge clock) disable iff (!arst_n) // see [R7]
    w83[8:0] == (sup83_flags[8:0] & 9'h17F))
    else $error("Word 83 flags wrong");
  a_w82_flags: assert property (@(posedge clock) disable iff (!arst_n) // see [R5]
    w82[14] == sup82_flags[14] && w82[0] == sup82_flags[0])
    else $error("Word 82 flags wrong");

  // Read path checks.
  a_read_lat: assert property (@(posedge clock) disable iff (!arst_n)
    rd_req |-> ##2 rd_valid)
    else $error("Read answer late");
  a_valid_pulse: assert property (@(posedge clock) disable iff (!arst_n)
    !rd_req |-> ##2 !rd_valid)
    else $error("Read answer without request");
  a_show_state: assert property (@(posedge clock) disable iff (!arst_n)
    (state_ff == ICW_SHOW) == rd_valid_ff)
    else $error("Read state and valid disagree");
  a_read_unmapped: assert property (@(posedge clock) disable iff (!arst_n)
    rd_req && word_slot(rd_word) == 3'h7 |-> ##2 rd_data == RESET_WORD)
    else $error("Unmapped word not zero");
  a_read_major: assert property (@(posedge clock) disable iff (!arst_n) // see [R1]
    rd_req && rd_word == WORD_MAJOR |-> ##2 rd_data == $past(w80))
    else $error("Major word read wrong");
  a_read_udma: assert property (@(posedge clock) disable iff (!arst_n) // see [R10]
    rd_req && rd_word == WORD_UDMA |-> ##2 rd_data == $past(w88))
    else $error("Ultra DMA word read wrong");
endmodule

// ==== icw_host_model.sv ====
// Host adapter model that requests identify words one cycle at a time.
// Assumes the bench calls its tasks; it drives only at the falling edge.
`timescale 1ns/1ps
module icw_host_model (
  input wire logic clock,
  output logic rd_req,
  output logic [7:0] rd_word
);
  initial begin
    rd_req = 1'b0;
    rd_word = 8'h00;
  end
  task automatic ask(input logic [7:0] w);
    @(negedge clock);
    rd_req = 1'b1;
    rd_word = w;
  endtask
  // The released word line shows the inverse of its last value.
  task automatic rest();
    @(negedge clock);
    rd_req = 1'b0;
    rd_word = ~rd_word;
  endtask
endmodule

// ==== icw_capability_words_tb.sv ====
// Self-checking bench for the identify capability word generator.
// Assumes the host model issues reads and a queue holds expected words.
`timescale 1ns/1ps
module icw_capability_words_tb;
  import icw_pkg::*;
  logic clock, arst_n, rv, pw, usup, sreq, sclr, rd_req, rd_valid, w53;
  logic [3:0] maj;
  logic [15:0] minor, s82, s83, e82, e83, rd_data, seed, exp_w;
  logic [2:0] umax, smode;
  logic [7:0] rd_word;
  logic [15:0] expq[$];
  int num_errors = 0;
  int checks = 0;
  int sel = -1;
  icw_capability_words dut_u (.clock(clock), .arst_n(arst_n), .report_version(rv),
    .major_support(maj), .minor_code(minor), .sup82_flags(s82), .sup83_flags(s83),
    .en82_flags(e82), .en83_flags(e83), .setmax_pw_set(pw), .udma_max_mode(umax),
    .udma_supported(usup), .udma_sel_req(sreq), .udma_sel_mode(smode),
    .udma_sel_clear(sclr), .rd_req(rd_req), .rd_word(rd_word), .rd_valid(rd_valid),
    .rd_data(rd_data), .word53_udma_valid(w53));
  icw_host_model host_u (.clock(clock), .rd_req(rd_req), .rd_word(rd_word));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] expect_word(input logic [7:0] w);
    logic [15:0] r;
    r = 16'h0000;
    case (w)
      WORD_MAJOR: if (rv) r = {10'h000, maj, 2'b00};
      WORD_MINOR: if (rv) r = minor;
      WORD_SUP82: r = s82 & 16'h77EF;
      WORD_SUP83: r = (s83 & 16'h017F) | 16'h4000;
      WORD_EN85: r = e82 & s82 & 16'h77EF;
      WORD_EN86: r = {7'h00, pw & s83[8], e83[7:0] & s83[7:0] & 8'h7F};
      WORD_UDMA: if (usup) begin
        r[4:0] = 5'h1F >> (3'h4 - umax);
        if (sel >= 0) r[8 + sel] = 1'b1;
      end
      default: r = 16'h0000;
    endcase
    return r;
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] want);
    checks++;
    if (got !== want) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic want);
    checks++;
    if (got !== want) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (rd_valid === 1'b1) begin
      exp_w = (expq.size() == 0) ? ~rd_data : expq.pop_front();
      cmp(rd_data, exp_w);
    end
  end
  initial begin
    #50000;
    num_errors++;
    finish_test();
  end
  initial begin
    {arst_n, rv, pw, usup, sreq, sclr, maj, umax, smode} = '0;
    {minor, s82, s83, e82, e83} = '0;
    seed = 16'h001F;
    repeat (2) @(posedge clock);
    @(negedge clock) arst_n = 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge clock);
      seed = lfsr(seed);
      {rv, pw, usup, maj, smode} = seed[9:0];
      umax = 3'(seed[15:10] % 5);
      seed = lfsr(seed);
      minor = seed;
      seed = lfsr(seed);
      s82 = seed;
      seed = lfsr(seed);
      s83 = seed;
      seed = lfsr(seed);
      e82 = seed;
      seed = lfsr(seed);
      e83 = seed;
      if (i < 10) begin
        usup = 1'b1;
        umax = 3'h4;
        smode = 3'(i >> 1);
      end
      sclr = 1'b1;
      @(negedge clock);
      sclr = i[0];
      sreq = 1'b1;
      sel = (!i[0] && usup && smode <= umax) ? int'(smode) : -1;
      @(negedge clock);
      {sclr, sreq} = 2'b00;
      cmp_flag(w53, usup);
      for (int w = 80; w <= 88; w++) begin
        expq.push_back(expect_word(8'(w)));
        host_u.ask(8'(w));
      end
      expq.push_back(16'h0000);
      host_u.ask(WORD_VALID53);
      host_u.rest();
      repeat (3) @(negedge clock);
      $display("test %0d done", i);
    end
    cmp(16'(expq.size()), 16'h0000);
    finish_test();
  end
endmodule
